/* tc_timer_map.svh */
// Register offsets, field positions, reset values and counts of the timer and prescaler.
// Assumes a 32-bit AHB-Lite bus with one aligned word per register.
// How it works
// (R1) Clock source select zero counts one step per instruction cycle without prescaler.
// (R2) A count register write holds off incrementing for the next two instruction cycles.
// (R3) Clock source select one counts edges of the external count input.
// (R4) Source edge select zero counts rising edges, one counts falling edges.
// (R5) Prescaler assign routes the one prescaler to the timer or the watchdog.
// (R6) Assigned to the timer, the ratio field divides by 2 up to 256.
// (R7) Software can neither read nor write the prescaler counter.
// (R8) The prescaler output is sampled on phase two and phase four; the code samples it on phase two only.
// (R9) Unprescaled external input stays high and low two oscillator periods each.
// (R10) Prescaled external input period is four oscillator periods over the ratio.
// (R11) The external input is divided by an edge-driven counter with symmetrical output.
// (R12) The count steps some cycles after the qualifying edge, never on it.
// (R13) The same 8-bit divider is a timer prescaler or a watchdog postscaler.
// (R14) Assigned to the timer, every count register write clears the prescaler.
// (R15) Assigned to the watchdog, the watchdog clear also clears the prescaler.
// (R16) Every reset loads the prescaler counter with zeros.
// (R17) Assignment and ratio may change at any time without a reset.
// (R18) Software clears watchdog, then count, then writes the new assignment.
// (R19) With ratio 000 or 001, software writes an interim all-ones ratio first.
// (R20) Moving back to the timer, software clears the watchdog then writes assign zero.
// (R21) The count register is eight bits, read and write, unchanged by reset.
// (R22) Counter mode takes over the port C pin 5 direction as input.
// (R23) Ratio codes give timer 1:2 to 1:256 and watchdog 1:1 to 1:128.
// (R24) The count wraps from its maximum to zero and keeps counting.
`ifndef TC_TIMER_MAP_SVH
`define TC_TIMER_MAP_SVH

`define TC_IDX_TIMER_COUNT    32'h0000_0001
`define TC_IDX_OPTION_CONTROL 32'h0000_0002
`define TC_IDX_PORT_C_DIR     32'h0000_0003
`define TC_IDX_WDT_CLEAR      32'h0000_0004

`define TC_BIT_CLOCK_SOURCE   5
`define TC_BIT_SOURCE_EDGE    4
`define TC_BIT_PRESCALE_ASSN  3
`define TC_BIT_RATIO_HI       2
`define TC_BIT_RATIO_LO       0
`define TC_BIT_WDT_CLEAR      0

`define TC_RST_OPTION         8'hff
`define TC_RST_PORT_C_DIR     6'h3f
`define TC_HOLDOFF_CYCLES     2'h2

`endif

/* tc_types_pkg.sv */
// Types used by the timer's instruction cycle sequencer; the prescaler uses none of them.
// Assumes the instruction cycle is four system clocks.
package tc_types_pkg;

  typedef enum logic [3:0] {
    PH_ONE   = 4'b0001,
    PH_TWO   = 4'b0010,
    PH_THREE = 4'b0100,
    PH_FOUR  = 4'b1000
  } phase_t;

endpackage

/* tc_prescaler.sv */
// Shared 8-bit divider used as timer prescaler or watchdog postscaler.
// Assumes a one-cycle count enable from the owner and a synchronous reset.
`timescale 1ns/100ps
`default_nettype none

module tc_prescaler #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_clear,
  input  wire logic             i_count,
  input  wire logic [2:0]       i_tap_sel,
  output logic                  o_tap,
  output logic                  o_zero
);

  logic [WIDTH-1:0] count;

  // Each bit toggles at half the rate of the one below, so every tap is symmetrical.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      count <= '0; // [R16]
    end else if (i_clear) begin
      count <= '0;
    end else if (i_count) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1}; // [R11] [R13]
    end
  end

  assign o_tap  = count[i_tap_sel];
  assign o_zero = (count == '0);

endmodule

`default_nettype wire

/* timer_zero_unit.sv */
// Top of the 8-bit timer/counter with shared prescaler and its AHB-Lite register slave.
// Assumes external inputs are synchronous to I_CLK_SYS and a watchdog counter outside.
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "tc_timer_map.svh"

module timer_zero_unit (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST_N,
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic      [31:0] O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP,
  input  wire logic        I_EXT_COUNT,
  input  wire logic        I_WDT_TICK,
  output logic             O_WDT_TICK,
  output logic             O_WDT_CLEAR,
  output logic      [5:0]  O_PORTC_DIR,
  output logic             O_TIMER_WRAP
);

  tc_types_pkg::phase_t phase;
  tc_types_pkg::phase_t next_phase;

  logic [7:0]  timer_count;
  logic [7:0]  option_control;
  logic [5:0]  port_c_direction;
  logic [1:0]  holdoff;
  logic        dp_write;
  logic [31:0] dp_addr;
  logic        edge_prev;
  logic        sample_two;
  logic        sample_four;
  logic        wdt_tap_prev;
  logic        pre_tap;
  logic        pre_zero;
  logic        pre_clear;
  logic        pre_count;
  logic [2:0]  tap_sel;
  logic        addr_valid;
  logic        wr_count;
  logic        wdt_clear;
  logic        clock_source_select;
  logic        source_edge_select;
  logic        prescaler_assign;
  logic [2:0]  prescale_ratio;
  logic        phase_two;
  logic        phase_four;
  logic        edge_level;
  logic        ext_edge;
  logic        src_level;
  logic        src_rise;
  logic        step_req;
  logic        step;
  logic        wdt_tick_out;

  // Word address match against a register index.
  function automatic logic addr_is(input logic [31:0] addr, input logic [31:0] idx);
    addr_is = (addr[31:2] == idx[29:0]) && (addr[1:0] == 2'b00);
  endfunction

  // Bus address phase and write strobes.
  assign addr_valid = I_HSEL && I_HTRANS[1] && I_HREADY;
  assign wr_count   = dp_write && addr_is(dp_addr, `TC_IDX_TIMER_COUNT);
  assign wdt_clear  = dp_write && addr_is(dp_addr, `TC_IDX_WDT_CLEAR)
                      && I_HWDATA[`TC_BIT_WDT_CLEAR];

  assign O_HREADYOUT = 1'b1;
  assign O_HRESP     = 1'b0;

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      dp_write <= 1'b0;
      dp_addr  <= 32'h0000_0000;
    end else begin
      dp_write <= addr_valid && I_HWRITE;
      if (addr_valid) begin
        dp_addr <= I_HADDR;
      end
    end
  end

  // Only the count register reads back; a write still in its data phase is forwarded.
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      O_HRDATA <= 32'h0000_0000;
    end else if (addr_valid && !I_HWRITE) begin
      if (addr_is(I_HADDR, `TC_IDX_TIMER_COUNT)) begin
        if (wr_count) begin
          O_HRDATA <= {24'h00_0000, I_HWDATA[7:0]};
        end else if (step) begin
          O_HRDATA <= {24'h00_0000, timer_count + 8'h01};
        end else begin
          O_HRDATA <= {24'h00_0000, timer_count}; // [R21]
        end
      end else begin
        O_HRDATA <= 32'h0000_0000; // [R7]
      end
    end
  end

  // Write-only option and direction registers.
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      option_control   <= `TC_RST_OPTION;
      port_c_direction <= `TC_RST_PORT_C_DIR;
    end else if (dp_write) begin
      if (addr_is(dp_addr, `TC_IDX_OPTION_CONTROL)) begin
        option_control <= I_HWDATA[7:0]; // [R17]
      end else if (addr_is(dp_addr, `TC_IDX_PORT_C_DIR)) begin
        port_c_direction <= I_HWDATA[5:0];
      end
    end
  end

  assign clock_source_select = option_control[`TC_BIT_CLOCK_SOURCE];
  assign source_edge_select  = option_control[`TC_BIT_SOURCE_EDGE];
  assign prescaler_assign    = option_control[`TC_BIT_PRESCALE_ASSN];
  assign prescale_ratio      = option_control[`TC_BIT_RATIO_HI:`TC_BIT_RATIO_LO];

  // Counter mode forces pin 5 to input.
  assign O_PORTC_DIR = {port_c_direction[5] | clock_source_select,
                        port_c_direction[4:0]}; // [R22]

  // Four-phase instruction cycle sequencer.
  always_comb begin
    case (phase)
      tc_types_pkg::PH_ONE:   next_phase = tc_types_pkg::PH_TWO;
      tc_types_pkg::PH_TWO:   next_phase = tc_types_pkg::PH_THREE;
      tc_types_pkg::PH_THREE: next_phase = tc_types_pkg::PH_FOUR;
      default:                next_phase = tc_types_pkg::PH_ONE;
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      phase <= tc_types_pkg::PH_ONE;
    end else begin
      phase <= next_phase;
    end
  end

  assign phase_two  = (phase == tc_types_pkg::PH_TWO);
  assign phase_four = (phase == tc_types_pkg::PH_FOUR);

  // Edge select inverts the input so that the counted edge is always a rise.
  assign edge_level = I_EXT_COUNT ^ source_edge_select; // [R4]
  assign ext_edge   = edge_level && !edge_prev;

  // Reset high so that an idle source level gives no false edge after a reset.
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      edge_prev <= 1'b1;
    end else begin
      edge_prev <= edge_level;
    end
  end

  // Prescaler input, clear and tap selection follow the assignment.
  always_comb begin
    if (prescaler_assign) begin
      pre_count = I_WDT_TICK; // [R5] [R13]
      pre_clear = wdt_clear; // [R15]
      tap_sel   = prescale_ratio - 3'h1; // [R23]
    end else begin
      pre_count = clock_source_select ? ext_edge : phase_four; // [R5]
      pre_clear = wr_count; // [R14]
      tap_sel   = prescale_ratio; // [R6] [R23]
    end
  end

  tc_prescaler #(
    .WIDTH     (8)
  ) u_prescaler (
    .i_clk     (I_CLK_SYS),
    .i_rst_n   (I_RST_N),
    .i_clear   (pre_clear),
    .i_count   (pre_count),
    .i_tap_sel (tap_sel),
    .o_tap     (pre_tap),
    .o_zero    (pre_zero)
  );

  // Divided or raw source sampled on phase two; phase four copies that phase-two sample.
  assign src_level = prescaler_assign ? edge_level : pre_tap;

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      sample_two  <= 1'b1;
      sample_four <= 1'b1;
    end else begin
      if (phase_two) begin
        sample_two <= src_level; // [R8]
      end
      if (phase_four) begin
        sample_four <= sample_two; // [R8]
      end
    end
  end

  assign src_rise = phase_four && sample_two && !sample_four; // [R12]

  // Step request per instruction cycle in plain timer mode, else on a synchronised rise.
  always_comb begin
    if (!clock_source_select && prescaler_assign) begin
      step_req = phase_four; // [R1]
    end else begin
      step_req = src_rise; // [R3] [R6]
    end
  end

  assign step = step_req && (holdoff == 2'h0) && !wr_count;

  // Holdoff after a count write.
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      holdoff <= 2'h0;
    end else if (wr_count) begin
      holdoff <= `TC_HOLDOFF_CYCLES; // [R2]
    end else if (phase_four && (holdoff != 2'h0)) begin
      holdoff <= holdoff - 2'h1; // [R2]
    end
  end

  // The count keeps its value through reset.
  always_ff @(posedge I_CLK_SYS) begin
    if (wr_count) begin
      timer_count <= I_HWDATA[7:0]; // [R21]
    end else if (step) begin
      timer_count <= timer_count + 8'h01; // [R24]
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      O_TIMER_WRAP <= 1'b0;
    end else begin
      O_TIMER_WRAP <= step && (timer_count == 8'hff); // [R24]
    end
  end

  // Watchdog postscaler output and watchdog clear pulse.
  assign wdt_tick_out = !prescaler_assign ? I_WDT_TICK :
                        (prescale_ratio == 3'h0) ? I_WDT_TICK :
                        (pre_tap && !wdt_tap_prev); // [R23]

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      wdt_tap_prev <= 1'b0;
      O_WDT_TICK   <= 1'b0;
      O_WDT_CLEAR  <= 1'b0;
    end else begin
      wdt_tap_prev <= pre_tap;
      O_WDT_TICK   <= wdt_tick_out; // [R13]
      O_WDT_CLEAR  <= wdt_clear;
    end
  end

  chk_timer_step: assert property ( // [R1]
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    phase_four && !clock_source_select && prescaler_assign && (holdoff == 2'h0) && !wr_count
    |=> timer_count == $past(timer_count) + 8'h01)
    else $error("timer mode did not step once per instruction cycle");

  chk_write_holdoff: assert property ( // [R2]
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    wr_count ##1 (!wr_count)[*8] |-> $stable(timer_count))
    else $error("count stepped during write holdoff");

  chk_holdoff_ends: assert property ( // [R2]
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    wr_count ##1 (!wr_count)[*8] |=> holdoff == 2'h0)
    else $error("holdoff did not end after two instruction cycles");

  chk_counter_phase: assert property ( // [R8]
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    clock_source_select && !phase_four |-> !step)
    else $error("counter mode stepped outside phase four");

  chk_count_wrap: assert property ( // [R24]
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    step && (timer_count == 8'hff) |=> (timer_count == 8'h00) && O_TIMER_WRAP)
    else $error("count did not wrap to zero");

  chk_timer_clear: assert property ( // [R14]
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    wr_count && !prescaler_assign |=> pre_zero)
    else $error("count write did not clear prescaler");

  chk_wdt_clear: assert property ( // [R15]
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    wdt_clear && prescaler_assign |=> pre_zero && O_WDT_CLEAR)
    else $error("watchdog clear did not clear prescaler");

  chk_reset_zero: assert property ( // [R16]
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    $rose(I_RST_N) |-> pre_zero)
    else $error("prescaler not zero after reset");

  chk_pin5_dir: assert property ( // [R22]
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    clock_source_select |-> O_PORTC_DIR[5])
    else $error("pin 5 not forced to input in counter mode");

  chk_wdt_bypass: assert property ( // [R23]
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    prescaler_assign && (prescale_ratio == 3'h0) |-> ##1 (O_WDT_TICK == $past(I_WDT_TICK)))
    else $error("watchdog ratio 1:1 did not pass the tick");

endmodule

`default_nettype wire

/* tc_ext_source.sv */
// Model of the external source that drives the timer count input.
// Assumes its tasks are called at a rising edge of i_clk; it idles low between bursts.
`timescale 1ns/100ps
`default_nettype none

module tc_ext_source (
  input  wire logic i_clk,
  output logic      o_ext
);
  initial begin
    o_ext = 1'b0;
  end

  // Changes the level, then holds it for the given number of cycles.
  task automatic set_level(input logic lvl, input int hold);
    o_ext <= lvl;
    repeat (hold) @(posedge i_clk);
  endtask

  // Sends whole pulses, each level held for the given number of cycles, ending low.
  task automatic pulses(input int n, input int per_level);
    for (int k = 0; k < n; k++) begin
      set_level(1'b1, per_level);
      set_level(1'b0, per_level);
    end
  endtask
endmodule

`default_nettype wire

/* tb.sv */
// Self-checking bench of the timer, its prescaler and the register slave.
// Assumes the external source model and a 10 MHz system clock.
`timescale 1ns/100ps
`default_nettype none
`include "tc_timer_map.svh"
`define CHECK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %0h", $time, g); end end

module tb;
  localparam logic [31:0] A_CNT = `TC_IDX_TIMER_COUNT << 2;
  localparam logic [31:0] A_OPT = `TC_IDX_OPTION_CONTROL << 2;
  localparam logic [31:0] A_DIR = `TC_IDX_PORT_C_DIR << 2;
  localparam logic [31:0] A_CLR = `TC_IDX_WDT_CLEAR << 2;
  logic        clk;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        ext;
  logic        wdt_in = 1'b0;
  logic        wdt_out;
  logic        wdt_clr;
  logic [5:0]  dir;
  logic        wrap;
  logic [31:0] rd;
  logic [5:0]  dr;
  int          fails = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          n_wdt = 0;
  int          n_clr = 0;
  int          n_wrap = 0;
  int          mark;
  int          v;

  timer_zero_unit i_timer_zero_unit (
    .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'b010), .I_HWDATA(hwdata),
    .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
    .I_EXT_COUNT(ext), .I_WDT_TICK(wdt_in), .O_WDT_TICK(wdt_out),
    .O_WDT_CLEAR(wdt_clr), .O_PORTC_DIR(dir), .O_TIMER_WRAP(wrap)
  );
  tc_ext_source i_tc_ext_source (.i_clk(clk), .o_ext(ext));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (wdt_out === 1'b1) n_wdt++;
    if (wdt_clr === 1'b1) n_clr++;
    if (wrap === 1'b1) n_wrap++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end

  function automatic logic [31:0] w8(input int x);
    return 32'(x & 255);
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= 1'b1;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
  endtask

  task automatic bus_read(input logic [31:0] a, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= 1'b0;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    do @(posedge clk); while (hready !== 1'b1);
    d = hrdata;
  endtask

  // Reads the count twice, len cycles apart, and expects the given number of steps.
  task automatic span_check(input int len, input int steps);
    logic [31:0] a;
    bus_read(A_CNT, a);
    tick(len - 2);
    bus_read(A_CNT, rd);
    `CHECK(rd, w8(int'(a[7:0]) + steps))
  endtask

  task automatic conclude();
    $display("comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    void'($urandom(65488));
    tick(10);
    rst_n <= 1'b1;
    tick(1);
    `CHECK(dir, 6'h3f)
    `CHECK(hresp, 1'b0)
    bus_write(32'h0000_0020, 32'hffff_ffff);
    bus_read(A_OPT, rd);
    `CHECK(rd, 32'h0000_0000)
    bus_read(32'h0000_0020, rd);
    `CHECK(rd, 32'h0000_0000)
    $display("test registers done");
    bus_write(A_CNT, 32'h0000_0000);
    bus_write(A_OPT, 32'h0000_0008);
    dr = 6'($urandom) & 6'h1f;
    bus_write(A_DIR, 32'(dr));
    tick(1);
    `CHECK(dir, dr)
    for (int t = 0; t < 2; t++) begin
      v = (t == 0) ? 254 : int'($urandom_range(255));
      mark = n_wrap;
      bus_write(A_CNT, 32'(v));
      bus_read(A_CNT, rd);
      `CHECK(rd, w8(v))
      tick(38);
      bus_read(A_CNT, rd);
      `CHECK(rd, w8(v + 8))
      `CHECK(n_wrap - mark, int'(v + 8 > 255))
    end
    span_check(400, 100);
    $display("test timer done");
    bus_write(A_CLR, 32'h0000_0001);
    for (int r = 0; r < 8; r++) begin
      bus_write(A_OPT, 32'(r));
      tick(4);
      span_check(16 << r, 2);
    end
    bus_write(A_CNT, 32'h0000_0000);
    tick(490);
    bus_read(A_CNT, rd);
    `CHECK(rd, 32'h0000_0000)
    tick(40);
    bus_read(A_CNT, rd);
    `CHECK(rd, 32'h0000_0001)
    $display("test prescaler done");
    bus_write(A_CLR, 32'h0000_0001);
    bus_write(A_CNT, 32'h0000_0000);
    bus_write(A_OPT, 32'h0000_000f);
    for (int k = 0; k < 8; k++) begin
      bus_write(A_OPT, 32'(8 | k));
      mark = n_clr;
      bus_write(A_CLR, 32'h0000_0001);
      tick(2);
      `CHECK(n_clr - mark, 1)
      mark = n_wdt;
      for (int j = 0; j < (2 << k); j++) begin
        wdt_in <= 1'b1;
        tick(1);
        wdt_in <= 1'b0;
        tick(1);
      end
      tick(3);
      `CHECK(n_wdt - mark, 2)
    end
    span_check(400, 100);
    $display("test watchdog done");
    for (int e = 0; e < 2; e++) begin
      bus_write(A_OPT, 32'(8'h28 | (e << 4)));
      i_tc_ext_source.set_level(1'b0, 8);
      `CHECK(dir, dr | 6'h20)
      bus_read(A_CNT, rd);
      v = int'(rd[7:0]);
      i_tc_ext_source.set_level(1'b1, 0);
      bus_read(A_CNT, rd);
      `CHECK(rd, w8(v))
      tick(10);
      bus_read(A_CNT, rd);
      `CHECK(rd, w8(v + int'(e == 0)))
      i_tc_ext_source.set_level(1'b0, 10);
      bus_read(A_CNT, rd);
      `CHECK(rd, w8(v + 1))
    end
    $display("test counter done");
    bus_write(A_CLR, 32'h0000_0001);
    for (int r = 0; r < 3; r += 2) begin
      bus_write(A_OPT, 32'(8'h20 | r));
      bus_write(A_CNT, 32'h0000_0000);
      tick(12);
      i_tc_ext_source.pulses(4 << r, 2);
      tick(12);
      bus_read(A_CNT, rd);
      `CHECK(rd, 32'h0000_0002)
    end
    $display("test prescaled counter done");
    conclude();
  end
endmodule

`default_nettype wire
